// ### bench/smbus_host_model.sv
module smbus_host_model (
   output logic scl_o,
   output logic sda_pull_o,
   input wire logic sda_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // bus idles released; scl stands still between frames
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end

   //////////////////////////////////////////////////////////////////////
   // start, also used as repeated start from scl low
   task automatic start();
      #20 sda_pull_o = 1'b0;
      #60 scl_o = 1'b1;
      #40 sda_pull_o = 1'b1;
      #40 scl_o = 1'b0;
   endtask : start

   // stop leaves both lines released
   task automatic stop();
      #20 sda_pull_o = 1'b1;
      #60 scl_o = 1'b1;
      #40 sda_pull_o = 1'b0;
      #80;
   endtask : stop

   // data changes only while scl is low
   task automatic send_bit(input logic b);
      #20 sda_pull_o = ~b;
      #60 scl_o = 1'b1;
      #80 scl_o = 1'b0;
   endtask : send_bit

   // sample mid-high, after the device had 120 ns to settle
   task automatic take_bit(output logic b);
      #20 sda_pull_o = 1'b0;
      #60 scl_o = 1'b1;
      #40 b = sda_i;
      #40 scl_o = 1'b0;
   endtask : take_bit

   // msb first, then the device's acknowledge
   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         send_bit(d[i]);
      end
      take_bit(b);
      ack = ~b;
   endtask : write_byte

   // last byte is refused so the device lets go
   task automatic read_byte(input logic last, output logic [7:0] d);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         take_bit(b);
         d[i] = b;
      end
      send_bit(last);
   endtask : read_byte
endmodule : smbus_host_model

// ### bench/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import smbus_front_pkg::*;

   localparam logic [7:0] STATUS_CMD = 8'he0;
   typedef struct packed {logic [1:0] hi; logic [1:0] lo; logic [6:0] adr;} row_t;
   localparam row_t ROWS [10] = '{'{2'h0, 2'h0, 7'h5c}, '{2'h0, 2'h1, 7'h5d},
      '{2'h0, 2'h2, 7'h5e}, '{2'h1, 2'h0, 7'h5f}, '{2'h1, 2'h1, 7'h60}, '{2'h1, 2'h2, 7'h61},
      '{2'h2, 2'h0, 7'h62}, '{2'h2, 2'h1, 7'h63}, '{2'h2, 2'h2, 7'h64}, '{2'h3, 2'h3, 7'h60}};
   localparam logic [7:0] BUSY_CMDS [8] = '{CMD_STORE_ALL, CMD_RESTORE_ALL, CMD_OV_FAULT_LIM,
      CMD_UV_FAULT_LIM, 8'hd0, 8'hd1, 8'h61, 8'he1};

   logic ref_clk_i, nrst_i, base_addr_wr_i, long_timeout_i, op_done_i;
   logic [1:0] addr_select_hi_pin_i, addr_select_lo_pin_i;
   logic [6:0] base_addr_i, dev_addr_o, me;
   logic [7:0] status_i, rd_data_i, cmd_o, wr_data_o, d;
   logic sda_o, sda_oe_o, cmd_valid_o, wr_valid_o, rd_req_o, stop_o, pec_ok_o;
   logic timeout_o, busy_o, busy_fault_o, alert_out_n_o, scl_w, pull_w, ack, a2;
   wire logic sda_i;
   wire logic scl_clk_i;
   int miscompares = 0;
   int num_checks = 0;
   int n_cmd = 0;
   int n_rd = 0;
   int n_to = 0;
   int n_wr = 0;
   int n_stop = 0;
   logic [7:0] last_wr;
   int n;

   // open-drain wire with pull-up
   assign sda_i = ~(pull_w | (sda_oe_o & ~sda_o));
   assign scl_clk_i = scl_w;

   pmbus_slave_address_busy_ctrl #(.COMMON_CMD(STATUS_CMD), .TO_CYC(2000),
      .TO_LONG_CYC(4000), .CLR_CYC(50)) dut (.ref_clk_i, .nrst_i, .scl_clk_i, .sda_i,
      .sda_o, .sda_oe_o, .addr_select_hi_pin_i, .addr_select_lo_pin_i, .base_addr_wr_i,
      .base_addr_i, .long_timeout_i, .status_i, .rd_data_i, .op_done_i, .dev_addr_o, .cmd_o,
      .cmd_valid_o, .wr_data_o, .wr_valid_o, .rd_req_o, .stop_o, .pec_ok_o, .timeout_o,
      .busy_o, .busy_fault_o, .alert_out_n_o);

   smbus_host_model host (.scl_o(scl_w), .sda_pull_o(pull_w), .sda_i);

   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   // pulse counters, single-cycle outputs seen at every edge
   always @(posedge ref_clk_i) begin
      if (cmd_valid_o === 1'b1) n_cmd++;
      if (rd_req_o === 1'b1) n_rd++;
      if (timeout_o === 1'b1) n_to++;
      if (stop_o === 1'b1) n_stop++;
      // data byte only stands until the first scl rise of the next byte, so keep a copy
      if (wr_valid_o === 1'b1) begin
         n_wr++;
         last_wr = wr_data_o;
      end
   end

   //////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   // pins settle well before release, since they are caught only once
   task automatic do_reset(input logic [1:0] hi, input logic [1:0] lo);
      @(posedge ref_clk_i);
      addr_select_hi_pin_i <= hi;
      addr_select_lo_pin_i <= lo;
      nrst_i <= 1'b0;
      repeat (5) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      #1;
   endtask : do_reset

   task automatic probe(input logic [6:0] a, output logic k);
      host.start();
      host.write_byte({a, 1'b0}, k);
      host.stop();
   endtask : probe

   task automatic send(input logic [6:0] a, input logic [7:0] c, output logic k, output logic m);
      host.start();
      host.write_byte({a, 1'b0}, k);
      host.write_byte(c, m);
      host.stop();
   endtask : send

   task automatic rd(input logic [6:0] a, input logic [7:0] c, input int cnt, output logic [7:0] q);
      logic k;
      host.start();
      host.write_byte({a, 1'b0}, k);
      host.write_byte(c, k);
      host.start();
      host.write_byte({a, 1'b1}, k);
      for (int i = 1; i <= cnt; i++) host.read_byte(i == cnt, q);
      host.stop();
   endtask : rd

   task automatic finish_op();
      @(posedge ref_clk_i);
      op_done_i <= 1'b1;
      @(posedge ref_clk_i);
      op_done_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      #1;
   endtask : finish_op

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      for (int i = 0; i < 8; i++) r = r[7] ? ((r << 1) ^ PEC_POLY) : (r << 1);
      return r;
   endfunction : crc8

   //////////////////////////////////////////////////////////////////////
   // generous bound: the whole sequence needs roughly a third of it
   initial begin
      #500000;
      miscompares++;
      give_verdict();
   end

   initial begin
      nrst_i = 1'b0;
      base_addr_wr_i = 1'b0;
      base_addr_i = 7'h20;
      long_timeout_i = 1'b0;
      op_done_i = 1'b0;
      status_i = 8'h5a;
      rd_data_i = 8'ha5;
      addr_select_hi_pin_i = 2'h0;
      addr_select_lo_pin_i = 2'h0;
      foreach (ROWS[i]) begin
         do_reset(ROWS[i].hi, ROWS[i].lo);
         check("dev_addr", 8'(dev_addr_o), 8'(ROWS[i].adr));
         probe(ROWS[i].adr, ack);
         check("own ack", 8'(ack), 8'h1);
         probe(ROWS[i].adr + 7'h1, ack);
         check("other nack", 8'(ack), 8'h0);
         probe(GLOBAL_ADDR, ack);
         check("global ack", 8'(ack), 8'h1);
      end
      // new base on top of offset 4
      @(posedge ref_clk_i);
      base_addr_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      base_addr_wr_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      #1;
      me = 7'h24;
      check("new base", 8'(dev_addr_o), 8'(me));
      probe(me, ack);
      check("new ack", 8'(ack), 8'h1);
      // word write to a limit makes the device busy
      host.start();
      host.write_byte({me, 1'b0}, ack);
      host.write_byte(CMD_OV_FAULT_LIM, ack);
      host.write_byte(8'h33, ack);
      host.write_byte(8'h23, ack);
      host.stop();
      check("busy set", 8'(busy_o), 8'h1);
      check("word bytes", 8'(n_wr), 8'h2);
      check("word high byte", last_wr, 8'h23);
      rd(me, STATUS_CMD, 1, d);
      check("status busy", d, 8'h1a);
      check("no fault", 8'(busy_fault_o), 8'h0);
      n = n_cmd;
      send(me, 8'h01, ack, a2);
      check("addr ack busy", 8'(ack), 8'h1);
      check("cmd nack busy", 8'(a2), 8'h0);
      check("discarded", 8'(n_cmd - n), 8'h0);
      check("alert low", 8'(alert_out_n_o), 8'h0);
      finish_op();
      check("busy ends", 8'(busy_o), 8'h0);
      check("alert held", 8'(alert_out_n_o), 8'h0);
      rd(me, STATUS_CMD, 1, d);
      check("status idle", d, 8'h5a);
      host.start();
      host.write_byte({ALERT_RESP_ADDR, 1'b1}, ack);
      host.read_byte(1'b1, d);
      host.stop();
      check("ara ack", 8'(ack), 8'h1);
      check("ara data", d, {me, 1'b0});
      check("alert freed", 8'(alert_out_n_o), 8'h1);
      foreach (BUSY_CMDS[i]) begin
         send(me, BUSY_CMDS[i], ack, a2);
         check("busy cmd ack", 8'(a2), 8'h1);
         check("cmd code", cmd_o, BUSY_CMDS[i]);
         check("busy after stop", 8'(busy_o), 8'h1);
         finish_op();
         check("busy cleared", 8'(busy_o), 8'h0);
      end
      // fault, then clear-faults releases it after the settle time
      send(me, CMD_STORE_ALL, ack, a2);
      send(me, 8'h01, ack, a2);
      check("fault set", 8'(busy_fault_o), 8'h1);
      finish_op();
      send(me, CMD_CLEAR_FAULTS, ack, a2);
      check("clear accepted", 8'(a2), 8'h1);
      repeat (60) @(posedge ref_clk_i);
      #1;
      check("fault cleared", 8'(busy_fault_o), 8'h0);
      check("alert released", 8'(alert_out_n_o), 8'h1);
      n = n_rd;
      rd(me, 8'h20, 2, d);
      check("read data", d, 8'ha5);
      check("read reqs", 8'(n_rd - n), 8'h2);
      // good then corrupted checksum
      for (int k = 0; k < 2; k++) begin
         d = crc8(crc8(8'h00, {me, 1'b0}), 8'h01) ^ 8'(k);
         n = n_stop;
         host.start();
         host.write_byte({me, 1'b0}, ack);
         host.write_byte(8'h01, ack);
         host.write_byte(d, ack);
         host.stop();
         check("pec", 8'(pec_ok_o), 8'(k == 0));
         check("stop pulse", 8'(n_stop - n), 8'h1);
      end
      // stall with scl low, short then long limit
      for (int k = 0; k < 2; k++) begin
         @(posedge ref_clk_i);
         long_timeout_i <= k[0];
         #1;
         n = n_to;
         host.start();
         host.write_byte({me, 1'b0}, ack);
         repeat (2100) @(posedge ref_clk_i);
         check("short stall", 8'(n_to - n), 8'(k == 0));
         repeat (2000) @(posedge ref_clk_i);
         check("long stall", 8'(n_to - n), 8'h1);
         host.stop();
      end
      give_verdict();
   end
endmodule : tb

// ### design/level_sync.sv
module level_sync #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   if (WIDTH < 1) $error("level_sync needs WIDTH of at least one");

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] q;
   } sync_t;

   sync_t sync_ff;
   sync_t nxt_sync;

   // first stage feeds only the second stage
   always_comb begin
      nxt_sync.meta = d_i;
      nxt_sync.q = sync_ff.meta;
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync_ff <= '0;
      end else begin
         sync_ff <= nxt_sync;
      end
   end

   assign q_o = sync_ff.q;
endmodule : level_sync

// ### design/link_bit_sampler.sv
module link_bit_sampler (
   input wire logic scl_clk_i,
   input wire logic nrst_i,
   input wire logic sda_i,
   output logic bit_o,
   output logic tog_o
);
   typedef struct packed {
      logic bit_val;
      logic tog;
   } samp_t;

   samp_t samp_ff;
   samp_t nxt_samp;

   // data bit is held a full scl period, so the toggle qualifies it safely
   always_comb begin
      nxt_samp.bit_val = sda_i;
      nxt_samp.tog = ~samp_ff.tog;
   end

   always_ff @(posedge scl_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         samp_ff <= '0;
      end else begin
         samp_ff <= nxt_samp;
      end
   end

   assign bit_o = samp_ff.bit_val;
   assign tog_o = samp_ff.tog;
endmodule : link_bit_sampler

// ### design/pmbus_slave_address_busy_ctrl.sv
// How it works
// - answer at base address plus offset 0..8
// - offset decoded from two three-level pins
// - writable base address, reset value 0x5c
// - always answer global address, and alert-response address on reads
// - command while busy: fault, alert, discard
// - busy: ack address, nack command byte
// - common-status command always accepted, no fault
// - status bit 6 low while busy
// - storage commands keep device busy long
// - some setting writes cause short busy
// - busy counted from stop until op_done_i
// - clear-faults takes effect after delay
// - bus timeout and optional packet checking
// - byte, word, block, alert, group transactions
// - block read up to 255 bytes, long timeout
module pmbus_slave_address_busy_ctrl
   import smbus_front_pkg::*;
#(
   parameter logic [7:0] COMMON_CMD = 8'he0,
   parameter logic [7:0] CFG_CMD = 8'hd0,
   parameter logic [7:0] CFG_ALL_CMD = 8'hd1,
   parameter logic [7:0] RISE_CMD = 8'h61,
   parameter logic [7:0] DAC_CMD = 8'he1,
   parameter int TO_CYC = smbus_front_pkg::TIMEOUT_CYC,
   parameter int TO_LONG_CYC = smbus_front_pkg::LONG_TIMEOUT_CYC,
   parameter int CLR_CYC = smbus_front_pkg::CLR_DELAY_CYC
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic scl_clk_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [1:0] addr_select_hi_pin_i,
   input wire logic [1:0] addr_select_lo_pin_i,
   input wire logic base_addr_wr_i,
   input wire logic [6:0] base_addr_i,
   input wire logic long_timeout_i,
   input wire logic [7:0] status_i,
   input wire logic [7:0] rd_data_i,
   input wire logic op_done_i,
   output logic [6:0] dev_addr_o,
   output logic [7:0] cmd_o,
   output logic cmd_valid_o,
   output logic [7:0] wr_data_o,
   output logic wr_valid_o,
   output logic rd_req_o,
   output logic stop_o,
   output logic pec_ok_o,
   output logic timeout_o,
   output logic busy_o,
   output logic busy_fault_o,
   output logic alert_out_n_o
);
   import smbus_front_pkg::*;

   if (TO_LONG_CYC >= 2 ** TO_W || TO_CYC >= 2 ** TO_W || TO_CYC < 2)
      $error("timeout counts do not fit the timeout counter");
   if (CLR_CYC >= 2 ** CLR_W || CLR_CYC < 2) $error("clear delay does not fit its counter");

   typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK, S_SKIP} state_t;

   typedef struct packed {
      state_t st;
      logic [6:0] base;
      logic [3:0] offs;
      logic [1:0] strap;
      logic [7:0] sh;
      logic [3:0] bcnt;
      logic [7:0] idx;
      logic [7:0] tx;
      logic rw;
      logic ara;
      logic ack;
      logic oe;
      logic [7:0] cmd;
      logic trig;
      logic busy;
      logic bfault;
      logic [CLR_W-1:0] clr;
      logic [TO_W-1:0] to;
      logic [7:0] crc;
      logic cmd_v;
      logic wr_v;
      logic rd_r;
      logic stop_p;
      logic pec_ok;
      logic to_p;
      logic tog_q;
      logic scl_q;
      logic sda_q;
   } ctrl_t;

   ctrl_t s;
   ctrl_t n;
   logic scl_s;
   logic sda_s;
   logic tog_s;
   logic bit_raw;
   logic tog_raw;
   logic [3:0] pins_s;
   logic start_ev;
   logic stop_ev;
   logic rise_ev;
   logic fall_ev;
   logic [6:0] dev_addr;
   logic [7:0] status_byte;
   logic [7:0] load_byte;
   logic [TO_W-1:0] to_lim;

   ////////////////////////////////////////////////////////////////////////////////
   // link side and crossings

   link_bit_sampler u_sampler (
      .scl_clk_i(scl_clk_i),
      .nrst_i(nrst_i),
      .sda_i(sda_i),
      .bit_o(bit_raw),
      .tog_o(tog_raw)
   );

   level_sync #(.WIDTH(3)) u_line_sync (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .d_i({scl_clk_i, sda_i, tog_raw}),
      .q_o({scl_s, sda_s, tog_s})
   );

   level_sync #(.WIDTH(4)) u_pin_sync (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .d_i({addr_select_hi_pin_i, addr_select_lo_pin_i}),
      .q_o(pins_s)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [3:0] pin_level(input logic [1:0] p);
      // anything not clearly low or high is taken as open
      if (p == PIN_LOW) begin
         pin_level = 4'h0;
      end else if (p == PIN_HIGH) begin
         pin_level = 4'h2;
      end else begin
         pin_level = 4'h1;
      end
   endfunction : pin_level

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? {r[6:0], 1'b0} ^ PEC_POLY : {r[6:0], 1'b0};
      end
      crc8 = r;
   endfunction : crc8

   function automatic logic is_trig(input logic [7:0] c);
      is_trig = (c == CMD_STORE_ALL) || (c == CMD_RESTORE_ALL) || (c == CFG_CMD) ||
                (c == CFG_ALL_CMD) || (c == RISE_CMD) || (c == CMD_OV_FAULT_LIM) ||
                (c == CMD_UV_FAULT_LIM) || (c == DAC_CMD);
   endfunction : is_trig

   // bus events; start and stop only while scl is high
   assign start_ev = scl_s && s.scl_q && s.sda_q && !sda_s;
   assign stop_ev = scl_s && s.scl_q && !s.sda_q && sda_s;
   assign rise_ev = tog_s != s.tog_q;
   assign fall_ev = s.scl_q && !scl_s;
   assign dev_addr = 7'(s.base + {3'h0, s.offs});
   assign status_byte = {status_i[7], ~s.busy, status_i[5:0]};
   assign to_lim = long_timeout_i ? TO_W'(TO_LONG_CYC) : TO_W'(TO_CYC);
   // byte to send: own address on alert response, status, else user data
   assign load_byte = s.ara ? {dev_addr, 1'b0} :
                      (s.cmd == COMMON_CMD) ? status_byte : rd_data_i;

   ////////////////////////////////////////////////////////////////////////////////
   // protocol engine

   always_comb begin
      n = s;
      n.cmd_v = 1'b0;
      n.wr_v = 1'b0;
      n.rd_r = 1'b0;
      n.stop_p = 1'b0;
      n.to_p = 1'b0;
      n.tog_q = tog_s;
      n.scl_q = scl_s;
      n.sda_q = sda_s;
      // pins caught once, only after their synchroniser has refilled past reset
      if (s.strap != 2'h3) begin
         n.strap = 2'(s.strap + 1'b1);
      end
      if (s.strap == 2'h2) begin
         n.offs = 4'(pin_level(pins_s[3:2]) * PIN_LEVELS + pin_level(pins_s[1:0]));
      end
      if (base_addr_wr_i) begin
         n.base = base_addr_i;
      end
      // clears first so that a same-cycle set below wins
      if (op_done_i) begin
         n.busy = 1'b0;
      end
      if (s.clr != '0) begin
         n.clr = CLR_W'(s.clr - 1'b1);
         if (s.clr == CLR_W'(1)) begin
            n.bfault = 1'b0;
         end
      end
      // stalled bus: scl held low too long mid-frame
      if (s.st != S_IDLE && !scl_s) begin
         n.to = TO_W'(s.to + 1'b1);
      end else begin
         n.to = '0;
      end
      if (start_ev) begin
         n.st = S_RX;
         n.idx = '0;
         n.bcnt = '0;
         n.oe = 1'b0;
         n.crc = '0;
         n.ara = 1'b0;
      end else if (stop_ev) begin
         n.st = S_IDLE;
         n.oe = 1'b0;
         n.stop_p = 1'b1;
         n.pec_ok = (s.crc == 8'h00);
         n.trig = 1'b0;
         if (s.trig) begin
            n.busy = 1'b1;
         end
      end else if (s.to == to_lim) begin
         n.st = S_IDLE;
         n.oe = 1'b0;
         n.to_p = 1'b1;
         n.trig = 1'b0;
      end else begin
         case (s.st)
            S_RX: begin
               if (rise_ev) begin
                  n.sh = {s.sh[6:0], bit_raw};
                  n.bcnt = 4'(s.bcnt + 1'b1);
               end else if (fall_ev && s.bcnt == BITS_PER_BYTE) begin
                  n.bcnt = '0;
                  n.st = S_ACK;
                  n.crc = crc8(s.crc, s.sh);
                  if (s.idx == 8'h00) begin
                     n.rw = s.sh[0];
                     n.ara = s.sh[0] && s.sh[7:1] == ALERT_RESP_ADDR;
                     n.ack = s.sh[7:1] == dev_addr || s.sh[7:1] == GLOBAL_ADDR || n.ara;
                     if (n.ack && s.sh[0]) begin
                        n.trig = 1'b0;
                     end
                     if (n.ara) begin
                        n.bfault = 1'b0;
                     end
                  end else if (s.idx == 8'h01) begin
                     n.cmd = s.sh;
                     if (s.busy && s.sh != COMMON_CMD) begin
                        n.ack = 1'b0;
                        n.bfault = 1'b1;
                     end else begin
                        n.ack = 1'b1;
                        n.cmd_v = 1'b1;
                        n.trig = s.trig || is_trig(s.sh);
                        if (s.sh == CMD_CLEAR_FAULTS) begin
                           n.clr = CLR_W'(CLR_CYC);
                        end
                     end
                  end else begin
                     n.ack = 1'b1;
                     n.wr_v = 1'b1;
                  end
                  n.oe = n.ack;
               end
            end
            S_ACK: begin
               if (fall_ev) begin
                  n.oe = 1'b0;
                  if (s.idx != MAX_READ_BYTES) begin
                     n.idx = 8'(s.idx + 1'b1);
                  end
                  if (!s.ack) begin
                     n.st = S_SKIP;
                  end else if (s.rw && s.idx == 8'h00) begin
                     n.st = S_TX;
                     n.tx = load_byte;
                     n.oe = ~load_byte[7];
                     n.rd_r = !s.ara && s.cmd != COMMON_CMD;
                  end else begin
                     n.st = S_RX;
                  end
               end
            end
            S_TX: begin
               if (rise_ev) begin
                  n.bcnt = 4'(s.bcnt + 1'b1);
               end else if (fall_ev) begin
                  if (s.bcnt == BITS_PER_BYTE) begin
                     n.oe = 1'b0;
                     n.bcnt = '0;
                     n.st = S_MACK;
                  end else begin
                     n.tx = {s.tx[6:0], 1'b0};
                     n.oe = ~s.tx[6];
                  end
               end
            end
            S_MACK: begin
               if (rise_ev) begin
                  n.ack = ~bit_raw;
               end else if (fall_ev) begin
                  if (s.ack && s.idx != MAX_READ_BYTES) begin
                     n.st = S_TX;
                     n.idx = 8'(s.idx + 1'b1);
                     n.tx = load_byte;
                     n.oe = ~load_byte[7];
                     n.rd_r = !s.ara && s.cmd != COMMON_CMD;
                  end else begin
                     n.st = S_SKIP;
                  end
               end
            end
            S_SKIP: begin
               n.oe = 1'b0;
            end
            default: begin
               n.st = S_IDLE;
               n.oe = 1'b0;
            end
         endcase
      end
   end

   // whole control state in one register
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s <= '{st: S_IDLE, base: BASE_ADDR_RST, scl_q: 1'b1, sda_q: 1'b1, default: '0};
      end else begin
         s <= n;
      end
   end

   // open-drain: only ever pull low
   assign sda_o = 1'b0;
   assign sda_oe_o = s.oe;
   assign dev_addr_o = dev_addr;
   assign cmd_o = s.cmd;
   assign cmd_valid_o = s.cmd_v;
   assign wr_data_o = s.sh;
   assign wr_valid_o = s.wr_v;
   assign rd_req_o = s.rd_r;
   assign stop_o = s.stop_p;
   assign pec_ok_o = s.pec_ok;
   assign timeout_o = s.to_p;
   assign busy_o = s.busy;
   assign busy_fault_o = s.bfault;
   assign alert_out_n_o = ~s.bfault;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   logic byte_done;
   assign byte_done = s.st == S_RX && fall_ev && s.bcnt == BITS_PER_BYTE && !start_ev &&
                      !stop_ev && s.to != to_lim;

   own_addr_a: assert property (byte_done && s.idx == 8'h00 && s.sh[7:1] == dev_addr
      |=> sda_oe_o && s.st == S_ACK) else $error("own address not acknowledged");
   global_addr_a: assert property (byte_done && s.idx == 8'h00 &&
      (s.sh[7:1] == GLOBAL_ADDR || s.sh == {ALERT_RESP_ADDR, 1'b1}) |=> sda_oe_o)
      else $error("fixed address not acknowledged");
   busy_nack_a: assert property (byte_done && s.idx == 8'h01 && s.busy &&
      s.sh != COMMON_CMD |=> !sda_oe_o && busy_fault_o ##1 !alert_out_n_o)
      else $error("busy command byte not refused");
   common_ok_a: assert property (byte_done && s.idx == 8'h01 && s.sh == COMMON_CMD
      |=> sda_oe_o && cmd_valid_o && $stable(busy_fault_o))
      else $error("common status command refused");
   busy_stop_a: assert property (stop_ev && s.trig |=> busy_o[*2])
      else $error("busy not raised at stop");
   busy_end_a: assert property (op_done_i && !stop_ev |=> !busy_o ##0 status_byte[6])
      else $error("busy not released after operation");
   alert_hold_a: assert property ($fell(alert_out_n_o) |->
      !alert_out_n_o until ($past(s.clr) == CLR_W'(1) || $rose(s.ara)))
      else $error("alert released without service");
   stall_abort_a: assert property (s.st != S_IDLE && s.to == to_lim && !start_ev &&
      !stop_ev |=> s.st == S_IDLE && timeout_o && !sda_oe_o)
      else $error("stalled bus not abandoned");

   busy_hit_c: cover property (byte_done && s.idx == 8'h01 && s.busy);
   status_read_c: cover property (rd_req_o == 1'b0 && s.st == S_TX && s.cmd == COMMON_CMD);
   ara_read_c: cover property (s.ara && s.st == S_TX);
   timeout_c: cover property (timeout_o);
endmodule : pmbus_slave_address_busy_ctrl

// ### design/smbus_front_pkg.sv
package smbus_front_pkg;
   // timing base
   localparam int CLK_MHZ = 200;
   localparam int TIMEOUT_MS = 25;
   localparam int LONG_TIMEOUT_MS = 255;
   localparam int CLR_DELAY_US = 500;
   localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
   localparam int LONG_TIMEOUT_CYC = LONG_TIMEOUT_MS * 1000 * CLK_MHZ;
   localparam int CLR_DELAY_CYC = CLR_DELAY_US * CLK_MHZ;
   localparam int TO_W = 26;
   localparam int CLR_W = 17;
   // addressing
   localparam logic [6:0] BASE_ADDR_RST = 7'h5c;
   localparam logic [6:0] GLOBAL_ADDR = 7'h5b;
   localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
   localparam logic [1:0] PIN_LOW = 2'h0;
   localparam logic [1:0] PIN_HIGH = 2'h2;
   localparam logic [3:0] PIN_LEVELS = 4'h3;
   // fixed command codes
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_STORE_ALL = 8'h15;
   localparam logic [7:0] CMD_RESTORE_ALL = 8'h16;
   localparam logic [7:0] CMD_OV_FAULT_LIM = 8'h40;
   localparam logic [7:0] CMD_UV_FAULT_LIM = 8'h44;
   // status byte and transfer limits
   localparam int STATUS_NBUSY_BIT = 6;
   localparam logic [7:0] MAX_READ_BYTES = 8'hff;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] PEC_POLY = 8'h07;
endpackage : smbus_front_pkg
